// *** eia_pkg.sv ***
`default_nettype none
package eia_pkg;
  // ---------------------------------------------------------------
  // opcode fields and decoder constants
  // ---------------------------------------------------------------
  localparam int          DATA_ADDR_W      = 12;
  localparam int          PTR_W            = 12;
  localparam int          PC_W             = 21;
  localparam int          OPC_W            = 16;
  localparam int          F_LSB            = 0;
  localparam int          F_W              = 8;
  localparam int          ACC_SEL_BIT      = 8;
  localparam int          DEST_BIT         = 9;
  localparam logic [7:0]  IDX_LIMIT        = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT        = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK      = 4'hf;
  localparam logic [7:0]  PSUB_OPC_HI      = 8'he9;
  localparam int          PSUB_SEL_LSB     = 6;
  localparam logic [1:0]  PSUB_RET_SEL     = 2'h3;
  localparam int          PSUB_K_W         = 6;
  localparam int          STACK_PTR_IDX    = 2;
  localparam logic [PTR_W-1:0] PTR_RESET   = 12'h000;
  localparam logic [PC_W-1:0]  PC_RESET    = 21'h00000;
  localparam real         CLK_PERIOD_NS    = 20.0;
  localparam int          RET_IDLE_CYCLES  = 1;

  typedef enum logic [1:0] {
    EIA_RUN  = 2'b00,
    EIA_IDLE = 2'b01
  } eia_state_e;
endpackage
`default_nettype wire

// *** eia_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - one enable gates extended opcodes and indexing
// - disabled: access bank or bank-select literal
// - indexed address is stack pointer plus field
// - only fields up to 5Fh are indexed
// - remap covers byte and bit instructions with the access bit (a) clear only
// - zero stack pointer matches access RAM
// - destination bit keeps its meaning
// - d=0 to working reg, d=1 to file
module eia_decoder #(
  parameter int PTR_WIDTH = eia_pkg::PTR_W
) (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  wire logic                          ext_enable,
  input  wire logic                          insn_valid,
  input  wire logic [eia_pkg::OPC_W-1:0]     opcode,
  input  wire logic                          file_operand_insn,
  input  wire logic [3:0]                    bank_select_reg,
  input  wire logic [eia_pkg::PC_W-1:0]      return_stack_top,
  output logic [eia_pkg::DATA_ADDR_W-1:0]    operand_addr,
  output logic                               indexed_access,
  output logic                               dest_to_wreg,
  output logic                               dest_to_file,
  output logic [PTR_WIDTH-1:0]               indirect_pointer_reg [3],
  output logic [eia_pkg::PC_W-1:0]           pc_load_value,
  output logic                               pc_load,
  output logic                               pop_return,
  output logic                               idle_cycle,
  output logic                               illegal_ext_opcode
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic in_index_window(input logic [7:0] f);
    return f <= eia_pkg::IDX_LIMIT;
  endfunction

  function automatic logic [3:0] access_bank_of(input logic [7:0] f);
    return (f >= eia_pkg::ACC_SPLIT) ? eia_pkg::ACC_HI_BANK : 4'h0;
  endfunction

  function automatic logic is_pointer_subtract(input logic [eia_pkg::OPC_W-1:0] op);
    return op[eia_pkg::OPC_W-1 -: 8] == eia_pkg::PSUB_OPC_HI;
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  eia_pkg::eia_state_e state;
  eia_pkg::eia_state_e next_state;
  wire logic [7:0] f_field   = opcode[eia_pkg::F_LSB +: eia_pkg::F_W];
  wire logic       acc_sel   = opcode[eia_pkg::ACC_SEL_BIT];
  wire logic       dest_bit  = opcode[eia_pkg::DEST_BIT];
  wire logic       run       = insn_valid && (state == eia_pkg::EIA_RUN);
  wire logic       psub_opc  = is_pointer_subtract(opcode);
  wire logic [1:0] psub_sel  = opcode[eia_pkg::PSUB_SEL_LSB +: 2];
  wire logic [5:0] psub_k    = opcode[eia_pkg::PSUB_K_W-1:0];
  wire logic       do_psub   = run && psub_opc && ext_enable;
  wire logic       do_ret    = do_psub && (psub_sel == eia_pkg::PSUB_RET_SEL);
  wire logic       use_index = ext_enable && file_operand_insn && !acc_sel
                               && in_index_window(f_field);
  wire logic [PTR_WIDTH-1:0] stack_ptr = indirect_pointer_reg[eia_pkg::STACK_PTR_IDX];
  wire logic [PTR_WIDTH-1:0] idx_addr  = stack_ptr + {{(PTR_WIDTH-8){1'b0}}, f_field};
  wire logic [3:0] lit_bank  = acc_sel ? bank_select_reg : access_bank_of(f_field);

  assign operand_addr       = use_index ? idx_addr[eia_pkg::DATA_ADDR_W-1:0] : {lit_bank, f_field};
  assign indexed_access     = use_index;
  assign dest_to_wreg       = file_operand_insn && !dest_bit;
  assign dest_to_file       = file_operand_insn && dest_bit;
  assign illegal_ext_opcode = run && psub_opc && !ext_enable;
  assign pc_load            = do_ret;
  assign pop_return         = do_ret;
  assign pc_load_value      = return_stack_top;
  assign idle_cycle         = (state == eia_pkg::EIA_IDLE);

  // ---------------------------------------------------------------
  // pointer registers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      wire logic hit = do_psub && ((psub_sel == 2'(gi))
                       || (gi == eia_pkg::STACK_PTR_IDX && psub_sel == eia_pkg::PSUB_RET_SEL));
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          indirect_pointer_reg[gi] <= eia_pkg::PTR_RESET;
        end else if (clk_en && hit) begin
          indirect_pointer_reg[gi] <= indirect_pointer_reg[gi] - {{(PTR_WIDTH-6){1'b0}}, psub_k};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // return idle cycle
  // ---------------------------------------------------------------
  assign next_state = do_ret ? eia_pkg::EIA_IDLE : eia_pkg::EIA_RUN;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= eia_pkg::EIA_RUN;
    end else if (clk_en) begin
      case (state)
        eia_pkg::EIA_RUN:  state <= next_state;
        eia_pkg::EIA_IDLE: state <= eia_pkg::EIA_RUN;
        default:           state <= eia_pkg::EIA_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_ret;
    clk_en && do_ret;
  endsequence
  sequence s_idle_then_run;
    idle_cycle ##1 !idle_cycle;
  endsequence
  sequence s_ret_then_enabled;
    s_ret ##1 clk_en;
  endsequence

  AST_EXT_OFF_LITERAL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ext_enable |-> !indexed_access && !do_psub)
    else $error("extension active while disabled");
  AST_BANK_SELECT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!ext_enable && acc_sel) |-> operand_addr == {bank_select_reg, f_field})
    else $error("bank select address wrong");
  AST_INDEX_SUM: assert property (@(posedge clk_sys) disable iff (sys_rst)
    indexed_access |-> operand_addr == 12'(stack_ptr + 12'(f_field)))
    else $error("indexed address wrong");
  AST_LIMIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (f_field > 8'h5f) |-> !indexed_access)
    else $error("index above limit");
  AST_ALL_FILE_INSN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ext_enable && file_operand_insn && !acc_sel && f_field <= 8'h5f) |-> indexed_access)
    else $error("file instruction not indexed");
  AST_ZERO_SP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (indexed_access && stack_ptr == '0) |-> operand_addr == {4'h0, f_field})
    else $error("zero pointer not access RAM");
  AST_DEST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    file_operand_insn |-> (dest_to_file == dest_bit) && (dest_to_wreg != dest_bit))
    else $error("destination wrong");
  AST_RET_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ret_then_enabled |-> s_idle_then_run)
    else $error("no single idle after return");
  AST_PSUB_VAL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && do_psub && psub_sel == 2'h0) |=>
      indirect_pointer_reg[0] == $past(indirect_pointer_reg[0]) - 12'($past(psub_k)))
    else $error("pointer subtract wrong");

  // ---------------------------------------------------------------
  // checks: literal addressing, destination and disabled extension
  // ---------------------------------------------------------------
  AST_ACCESS_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!acc_sel && !ext_enable && f_field < 8'h60) |-> operand_addr == {4'h0, f_field})
    else $error("low access bank address wrong");
  AST_ACCESS_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!acc_sel && f_field > 8'h5f) |-> (operand_addr == {4'hf, f_field}) && !indexed_access)
    else $error("high access bank address wrong");
  AST_DEST_INDEXED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    indexed_access |-> (dest_to_file == dest_bit) && (dest_to_wreg == !dest_bit))
    else $error("destination changed by indexing");
  AST_ILLEGAL_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    illegal_ext_opcode |-> !ext_enable && !pc_load && !pop_return)
    else $error("extended opcode acted while disabled");
  AST_EXT_OFF_PTR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ext_enable |=> $stable(indirect_pointer_reg[0]) && $stable(indirect_pointer_reg[1])
                    && $stable(indirect_pointer_reg[2]))
    else $error("pointer moved while extension off");

  // ---------------------------------------------------------------
  // checks: subtract and return
  // ---------------------------------------------------------------
  AST_RET_ENTER_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ret |=> idle_cycle)
    else $error("no idle cycle after return");
  AST_RET_PC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_ret |-> pc_load && pop_return && (pc_load_value == return_stack_top))
    else $error("return did not load the program counter");
  AST_RET_SP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ret |=> stack_ptr == $past(stack_ptr) - 12'($past(psub_k)))
    else $error("return stack pointer wrong");
  AST_RET_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ret |=> $stable(indirect_pointer_reg[0]) && $stable(indirect_pointer_reg[1]))
    else $error("return touched another pointer");
  AST_IDLE_REFUSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    idle_cycle |-> !pc_load && !pop_return && !illegal_ext_opcode)
    else $error("instruction taken during idle cycle");
  AST_IDLE_PTR_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    idle_cycle |=> $stable(indirect_pointer_reg[0]) && $stable(indirect_pointer_reg[1])
                   && $stable(indirect_pointer_reg[2]))
    else $error("pointer changed during idle cycle");
  AST_PSUB_VAL1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && do_psub && psub_sel == 2'h1) |=>
      indirect_pointer_reg[1] == $past(indirect_pointer_reg[1]) - 12'($past(psub_k)))
    else $error("pointer one subtract wrong");
  AST_PSUB_VAL2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && do_psub && psub_sel == 2'h2) |=>
      indirect_pointer_reg[2] == $past(indirect_pointer_reg[2]) - 12'($past(psub_k)))
    else $error("stack pointer subtract wrong");
  AST_PSUB_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && do_psub && psub_sel == 2'h1) |=>
      $stable(indirect_pointer_reg[0]) && $stable(indirect_pointer_reg[2]))
    else $error("subtract touched another pointer");

  // ---------------------------------------------------------------
  // checks: clock enable
  // ---------------------------------------------------------------
  AST_FREEZE_PTR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(indirect_pointer_reg[0]) && $stable(indirect_pointer_reg[1])
                && $stable(indirect_pointer_reg[2]))
    else $error("pointer moved while clock enable low");
  AST_FREEZE_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(idle_cycle))
    else $error("idle state moved while clock enable low");
  AST_IDLE_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (idle_cycle && clk_en) |=> !idle_cycle)
    else $error("idle cycle lasted too long");
endmodule // eia_decoder
`default_nettype wire

// *** extended_insn_indexed_addressing_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module extended_insn_indexed_addressing_tb_top;
  logic        clk_sys, sys_rst, clk_en, ext_enable, insn_valid, file_operand_insn;
  logic        indexed_access, dest_to_wreg, dest_to_file, pc_load, pop_return, idle_cycle, illegal_ext_opcode;
  logic [15:0] opcode;
  logic [3:0]  bank_select_reg;
  logic [20:0] return_stack_top, pc_load_value;
  logic [11:0] operand_addr;
  logic [11:0] ptr [3];
  logic [11:0] mp [3];
  logic [15:0] cor [6] = '{16'h245f, 16'h2460, 16'h26ff, 16'h2500, 16'h7000, 16'h6e3a};
  logic [31:0] seed;
  int          n_errors, checks_done;
  eia_decoder DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .ext_enable(ext_enable),
    .insn_valid(insn_valid), .opcode(opcode), .file_operand_insn(file_operand_insn),
    .bank_select_reg(bank_select_reg), .return_stack_top(return_stack_top), .operand_addr(operand_addr),
    .indexed_access(indexed_access), .dest_to_wreg(dest_to_wreg), .dest_to_file(dest_to_file),
    .indirect_pointer_reg(ptr), .pc_load_value(pc_load_value), .pc_load(pc_load), .pop_return(pop_return),
    .idle_cycle(idle_cycle), .illegal_ext_opcode(illegal_ext_opcode));
  // ----
  // expectations
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic ixd(logic [15:0] op);
    return ext_enable && !op[8] && op[7:0] <= 8'h5f;
  endfunction
  function automatic logic [11:0] exp_addr(logic [15:0] op);
    if (ixd(op)) return mp[2] + op[7:0];
    if (op[8]) return {bank_select_reg, op[7:0]};
    return {(op[7:0] < 8'h60) ? 4'h0 : 4'hf, op[7:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_addr(input logic [15:0] op);
    opcode = op;
    file_operand_insn = 1'b1;
    insn_valid = 1'b1;
    #1;
    cmp(operand_addr, exp_addr(op));
    cmp(indexed_access, ixd(op));
    cmp({dest_to_file, dest_to_wreg}, {op[9], !op[9]});
    @(negedge clk_sys);
  endtask
  task automatic t_sub(input logic [1:0] s, input logic [5:0] k);
    logic r;
    r = ext_enable && s == 2'h3;
    opcode = {8'he9, s, k};
    file_operand_insn = 1'b0;
    insn_valid = 1'b1;
    #1;
    cmp({pc_load, pop_return, illegal_ext_opcode}, {r, r, !ext_enable});
    cmp(pc_load_value, return_stack_top);
    @(negedge clk_sys);
    insn_valid = r;
    if (ext_enable) mp[r ? 2 : s] -= k;
    #1;
    cmp({pc_load, pop_return, illegal_ext_opcode}, 3'h0);
    for (int i = 0; i < 3; i++) cmp(ptr[i], mp[i]);
    cmp(idle_cycle, r);
    @(negedge clk_sys);
    for (int i = 0; i < 3; i++) cmp(ptr[i], mp[i]);
    cmp(idle_cycle, 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    seed = 32'h66227ece;
    {n_errors, checks_done} = '0;
    {sys_rst, clk_en, ext_enable, insn_valid, file_operand_insn} = 5'b11100;
    opcode = 16'h0000;
    bank_select_reg = 4'h5;
    return_stack_top = 21'h1abcde;
    mp = '{default: 12'h000};
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int e = 1; e >= 0; e--) begin
      ext_enable = e[0];
      foreach (cor[i]) t_addr(cor[i]);
      for (int s = 0; s < 4; s++) t_sub(s[1:0], 6'h23);
      foreach (cor[i]) t_addr(cor[i]);
    end
    $display("test corner done");
    clk_en = 1'b0;
    ext_enable = 1'b1;
    opcode = 16'he9c5;
    file_operand_insn = 1'b0;
    insn_valid = 1'b1;
    @(negedge clk_sys);
    for (int i = 0; i < 3; i++) cmp(ptr[i], mp[i]);
    cmp(idle_cycle, 1'b0);
    clk_en = 1'b1;
    @(negedge clk_sys);
    mp[2] -= 6'h05;
    cmp(ptr[2], mp[2]);
    cmp(idle_cycle, 1'b1);
    insn_valid = 1'b0;
    sys_rst = 1'b1;
    mp = '{default: 12'h000};
    #1;
    for (int i = 0; i < 3; i++) cmp(ptr[i], mp[i]);
    cmp(idle_cycle, 1'b0);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    $display("test freeze and reset done");
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      ext_enable = r[31];
      bank_select_reg = r[30:27];
      return_stack_top = r[20:0];
      if (r[26:24] == 3'h0) t_sub(r[7:6], r[5:0]);
      else t_addr({r[23:16] ^ {7'h00, r[23:16] == 8'he9}, r[7:0]});
    end
    $display("test random done");
    test_done();
  end
endmodule // extended_insn_indexed_addressing_tb_top
`default_nettype wire
